// ---- tb_vid_decode_phase_shedding.sv ----
// Testbench: code decode, save mode entry and exit, phase count gates
`timescale 1ns/1ps
`default_nettype none

module tb_vid_decode_phase_shedding;
    import vps_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0, code_cmd = 8'h02, c, vid;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, err, save_cmd = 0, ase = 0, req_n;
    logic        g1, g2, g3, g4, save_mode, output_off;
    logic [20:0] dac;
    logic [15:0] ilim;
    logic [7:0]  corner [4] = '{8'h02, 8'hb2, 8'hfe, 8'hff};
    int          fails = 0, n_compared = 0, hi2, hi4;

    always #2 pclk = ~pclk;

    vps_cpu_model vps_cpu_model_i (.clk(pclk), .code_cmd(code_cmd),
        .save_cmd(save_cmd), .voltage_id_code(vid),
        .power_save_request_n(req_n));

    vps_phase_ctrl vps_phase_ctrl_i (.pclk(pclk), .presetn(presetn),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .voltage_id_code(vid),
        .power_save_request_n(req_n), .auto_save_enable(ase),
        .gate_out_one(g1), .gate_out_two(g2), .gate_out_three(g3),
        .gate_out_four(g4), .save_mode(save_mode), .output_off(output_off),
        .dac_target_uv(dac), .current_limit(ilim));

    // Table target: 6.25 mV per code step below the top code
    function automatic logic [20:0] exp_dac(input logic [7:0] k);
        if (k < CODE_FIRST || k > CODE_LAST)
            return 21'h0;
        return DAC_MAX_UV - 21'(k - CODE_FIRST) * STEP_UV;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // One APB transfer; waits for pready, then releases
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask

    // Pins settle: sync, decode and mode stages fit well inside 12 edges
    task automatic pins(input logic [7:0] k, input logic s, input logic e);
        @(posedge pclk);
        code_cmd <= k; save_cmd <= s; ase <= e;
        repeat (12) @(posedge pclk);
        #1;
    endtask

    task automatic results;
        if (fails == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(38));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, REG_CTRL, 0);
        chk("ctrl", 32'h4, rd);
        apb(0, 8'h1c, 0);
        chk("slverr", 1, err);
        // Table corners and off codes first, then random table codes
        for (int i = 0; i < 10; i++)
        begin
            c = i < 4 ? corner[i] : 8'h02 + 8'($urandom_range(176));
            pins(c, 0, 0);
            chk("dac", exp_dac(c), dac);
            chk("off", exp_dac(c) == 0, output_off);
        end
        apb(1, REG_DUTY, 32'h40);
        apb(1, REG_ILIM, 32'hc00);
        apb(1, REG_CTRL, 32'h104);
        // Park the code with auto saving off so the random history is gone
        pins(8'h40, 0, 0);
        pins(8'h40, 0, 1);
        chk("save", 0, save_mode);
        pins(8'h50, 0, 1);
        chk("save", 1, save_mode);
        chk("shed", 0, {g2, g3, g4});
        apb(0, REG_ILIM_EFF, 0);
        chk("ilim eff", 32'h300, rd);
        pins(8'h30, 0, 1);
        chk("save", 0, save_mode);
        pins(8'h60, 0, 0);
        chk("save", 0, save_mode);
        pins(8'h60, 1, 0);
        chk("save", 1, save_mode);
        pins(8'h60, 0, 0);
        chk("save", 0, save_mode);
        // Every phase count: mask and activity over one ramp period
        for (int p = 2; p <= 4; p++)
        begin
            apb(1, REG_CTRL, 32'h100 | p);
            apb(0, REG_STATUS, 0);
            apb(0, REG_STATUS, 0);
            chk("mask", p == 2 ? 4'h5 : p == 3 ? 4'h7 : 4'hf, rd[15:12]);
            hi2 = 0;
            hi4 = 0;
            repeat (250) @(posedge pclk) begin hi2 += g2; hi4 += g4; end
            chk("g2 used", p != 2, hi2 != 0);
            chk("g4 used", p == 4, hi4 != 0);
        end
        results();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #40000;
        fails++;
        results();
    end
endmodule

`default_nettype wire

// ---- vps_code_decode.sv ----
// Voltage code register, table decode and transition detector
`timescale 1ns/1ps
`default_nettype none

module vps_code_decode
    import vps_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic [7:0] code_in,
    vps_code_if.dec         dif
);

    logic [7:0]  code_reg;
    logic [7:0]  prev_reg;
    logic [1:0]  primed_reg;
    logic [20:0] dac_reg;
    logic        off_reg;
    logic        up_reg;
    logic        down_reg;
    logic        cur_ok;
    logic        prev_ok;
    logic [20:0] steps;

    // ----------------------------------------------------------------
    // Code history
    // ----------------------------------------------------------------
    // Two loads are needed before a compare is meaningful
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            code_reg   <= 8'h00;
            prev_reg   <= 8'h00;
            primed_reg <= 2'h0;
        end
        else if (ce)
        begin
            code_reg   <= code_in;
            prev_reg   <= code_reg;
            primed_reg <= {primed_reg[0], 1'b1};
        end
    end

    // Codes outside the table carry no voltage and do not count
    assign cur_ok  = (code_reg >= CODE_FIRST) && (code_reg <= CODE_LAST);
    assign prev_ok = (prev_reg >= CODE_FIRST) && (prev_reg <= CODE_LAST);
    assign steps   = {13'h0000, code_reg - CODE_FIRST};

    // ----------------------------------------------------------------
    // Decode and events
    // ----------------------------------------------------------------
    // A higher code is a lower voltage, so code up means voltage down
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dac_reg  <= 21'h000000;
            off_reg  <= 1'b1;
            up_reg   <= 1'b0;
            down_reg <= 1'b0;
        end
        else if (ce)
        begin
            dac_reg  <= cur_ok ? DAC_MAX_UV - steps * STEP_UV
                               : 21'h000000;
            off_reg  <= !cur_ok;
            down_reg <= primed_reg[1] && cur_ok && prev_ok
                        && (code_reg > prev_reg);
            up_reg   <= primed_reg[1] && cur_ok && prev_ok
                        && (code_reg < prev_reg);
        end
    end

    assign dif.code   = code_reg;
    assign dif.dac_uv = dac_reg;
    assign dif.off    = off_reg;
    assign dif.up     = up_reg;
    assign dif.down   = down_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_floor_code: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && code_reg == CODE_LAST) |=> (dac_reg == DAC_MIN_UV))
        else $error("Lowest code did not give 0.5 V");
    a_off_codes: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && (code_reg == CODE_OFF_A || code_reg == CODE_OFF_B))
        |=> off_reg)
        else $error("Off code did not switch output off");
    a_down_event: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && primed_reg[1] && cur_ok && prev_ok && code_reg > prev_reg)
        |=> (down_reg && !up_reg))
        else $error("Falling voltage not flagged");

endmodule

`default_nettype wire

// ---- vps_code_if.sv ----
// Interface: decoded voltage code and transition events
`timescale 1ns/1ps
`default_nettype none

interface vps_code_if;
    logic [7:0]  code;
    logic [20:0] dac_uv;
    logic        off;
    logic        up;
    logic        down;

    modport dec (output code, output dac_uv, output off,
                 output up, output down);
    modport ctl (input code, input dac_uv, input off,
                 input up, input down);
endinterface

`default_nettype wire

// ---- vps_cpu_model.sv ----
// Processor-side model: drives the voltage code and save request pins
`timescale 1ns/1ps
`default_nettype none

module vps_cpu_model (
    input  wire logic       clk,
    input  wire logic [7:0] code_cmd,
    input  wire logic       save_cmd,
    output var  logic [7:0] voltage_id_code,
    output var  logic       power_save_request_n
);
    // Pins idle at the top code with no request pending
    initial voltage_id_code = 8'h02;
    initial power_save_request_n = 1'b1;

    // All code bits move together, just after an edge, so no skewed code
    always @(posedge clk)
    begin
        voltage_id_code      <= code_cmd;
        power_save_request_n <= !save_cmd;
    end
endmodule

`default_nettype wire

// ---- vps_phase_ctrl.sv ----
// Phase shedding and voltage-code control with APB register access
//
// How it works
// - Decode 8-bit code to DAC target; B2 is 0.5 V, FE/FF mean off.
// - Watch the voltage code continuously for entry or exit transitions.
// - With auto saving enabled, voltage going down enters saving mode.
// - With auto saving enabled, voltage going up leaves saving mode.
// - In saving mode current limit is scaled by one over phase count.
// - The auto-save enable pin level turns automatic detection on or off.
// - Request pin low forces saving mode regardless of auto-save enable.
// - Saving mode runs gate one only and sheds every other phase.
// - Phase count of two, three or four sets the active gates.
// - Two phases drive gates one and three; gates two and four idle.
// - Three phases drive gates one to three; gate four idles.
// - Four phases drive all four gates with modulation.
// - Active phases are evenly spaced: half, third or quarter period.
`timescale 1ns/1ps
`default_nettype none

module vps_phase_ctrl
    import vps_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  voltage_id_code,
    input  wire logic        power_save_request_n,
    input  wire logic        auto_save_enable,
    output logic             gate_out_one,
    output logic             gate_out_two,
    output logic             gate_out_three,
    output logic             gate_out_four,
    output logic             save_mode,
    output logic             output_off,
    output logic      [20:0] dac_target_uv,
    output logic      [15:0] current_limit
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int SYNC_W = 10;

    vps_code_if dif ();

    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [7:0]        code_sync;
    logic              req_n_sync;
    logic              en_sync;

    logic [2:0]  phase_reg;
    logic        run_reg;
    logic [15:0] period_reg;
    logic [15:0] duty_reg;
    logic [15:0] ilim_reg;
    logic [15:0] ilim_eff_reg;
    logic        auto_reg;
    logic        save_reg;
    logic [15:0] cnt_reg;
    logic [3:0]  gate_reg;
    logic [3:0]  active;
    logic [15:0] p_half;
    logic [15:0] p_third;
    logic [15:0] p_quarter;
    logic [15:0] offs [4];
    logic [31:0] rdata_reg;
    logic        err_reg;
    logic        wr_en;
    logic        setup;
    logic        mapped;
    logic [31:0] rd_mux;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    assign pin_raw = {auto_save_enable, power_save_request_n,
                      voltage_id_code};

    // Code bits may settle a cycle apart; the decoder only counts
    // transitions between codes that sit inside the table.
    generate
        for (genvar i = 0; i < SYNC_W; i++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                end
                else if (ce)
                begin
                    sync1_reg[i] <= pin_raw[i];
                    sync2_reg[i] <= sync1_reg[i];
                end
            end
        end
    endgenerate

    assign code_sync  = sync2_reg[7:0];
    assign req_n_sync = sync2_reg[8];
    assign en_sync    = sync2_reg[9];

    // ----------------------------------------------------------------
    // Code decoder
    // ----------------------------------------------------------------
    vps_code_decode u_decode (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .code_in (code_sync),
        .dif     (dif.dec)
    );

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Zero wait states; read data is fetched in the setup cycle
    assign setup  = psel && !penable;
    assign wr_en  = ce && psel && penable && pwrite && !err_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && err_reg;
    assign prdata = rdata_reg;

    assign mapped = (paddr == REG_CTRL) || (paddr == REG_PERIOD)
                 || (paddr == REG_DUTY) || (paddr == REG_ILIM)
                 || (paddr == REG_STATUS) || (paddr == REG_DAC)
                 || (paddr == REG_ILIM_EFF);

    // Read mux; unused bits read as zero
    always_comb
    begin
        rd_mux = 32'h00000000;
        unique case (paddr)
            REG_CTRL:
            begin
                rd_mux[CTRL_PHASE_LSB +: 3] = phase_reg;
                rd_mux[CTRL_RUN_BIT]        = run_reg;
            end
            REG_PERIOD:   rd_mux[15:0] = period_reg;
            REG_DUTY:     rd_mux[15:0] = duty_reg;
            REG_ILIM:     rd_mux[15:0] = ilim_reg;
            REG_STATUS:
            begin
                rd_mux[ST_SAVE_BIT]        = save_reg;
                rd_mux[ST_OFF_BIT]         = dif.off;
                rd_mux[ST_AUTO_BIT]        = auto_reg;
                rd_mux[ST_REQ_BIT]         = !req_n_sync;
                rd_mux[ST_CODE_LSB +: 8]   = dif.code;
                rd_mux[ST_GATES_LSB +: 4]  = active;
            end
            REG_DAC:      rd_mux[20:0] = dif.dac_uv;
            REG_ILIM_EFF: rd_mux[15:0] = ilim_eff_reg;
            default:      rd_mux = 32'h00000000;
        endcase
    end

    // Capture answer at setup so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_reg <= 32'h00000000;
            err_reg   <= 1'b0;
        end
        else if (ce && setup)
        begin
            rdata_reg <= pwrite ? 32'h00000000 : rd_mux;
            err_reg   <= !mapped;
        end
    end

    // Writable registers; an illegal phase count leaves the old one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_reg  <= PHASE_RST;
            run_reg    <= RUN_RST;
            period_reg <= PERIOD_RST;
            duty_reg   <= DUTY_RST;
            ilim_reg   <= ILIM_RST;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                REG_CTRL:
                begin
                    if (pwdata[CTRL_PHASE_LSB +: 3] >= PH_TWO &&
                        pwdata[CTRL_PHASE_LSB +: 3] <= PH_FOUR)
                        phase_reg <= pwdata[CTRL_PHASE_LSB +: 3];
                    run_reg <= pwdata[CTRL_RUN_BIT];
                end
                REG_PERIOD: period_reg <= pwdata[15:0];
                REG_DUTY:   duty_reg   <= pwdata[15:0];
                REG_ILIM:   ilim_reg   <= pwdata[15:0];
                default:    ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Power saving decision
    // ----------------------------------------------------------------
    // Auto flag follows code transitions only while the pin allows it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            auto_reg <= 1'b0;
        else if (ce)
        begin
            if (!en_sync)
                auto_reg <= 1'b0;
            else if (dif.down)
                auto_reg <= 1'b1;
            else if (dif.up)
                auto_reg <= 1'b0;
        end
    end

    // Request pin outranks the auto path outright
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            save_reg <= 1'b0;
        else if (ce)
            save_reg <= !req_n_sync || auto_reg;
    end

    // Total limit shrinks to the share of the one running phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ilim_eff_reg <= ILIM_RST;
        else if (ce)
        begin
            if (!save_reg)
                ilim_eff_reg <= ilim_reg;
            else
            begin
                unique case (phase_reg)
                    PH_TWO:   ilim_eff_reg <= ilim_reg >> 1;
                    PH_THREE: ilim_eff_reg <= ilim_reg / 16'h0003;
                    default:  ilim_eff_reg <= ilim_reg >> 2;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Phase selection and spacing
    // ----------------------------------------------------------------
    // Two-phase boards wire gates one and three; saving keeps gate one
    always_comb
    begin
        if (save_reg)
            active = 4'h1;
        else
        begin
            unique case (phase_reg)
                PH_TWO:   active = 4'h5;
                PH_THREE: active = 4'h7;
                default:  active = 4'hf;
            endcase
        end
    end

    assign p_half    = period_reg >> 1;
    assign p_quarter = period_reg >> 2;
    assign p_third   = period_reg / 16'h0003;

    // Ramp offsets per gate for even angular spacing
    always_comb
    begin
        offs[0] = 16'h0000;
        offs[1] = 16'h0000;
        offs[2] = 16'h0000;
        offs[3] = 16'h0000;
        unique case (phase_reg)
            PH_TWO:   offs[2] = p_half;
            PH_THREE:
            begin
                offs[1] = p_third;
                offs[2] = p_third << 1;
            end
            default:
            begin
                offs[1] = p_quarter;
                offs[2] = p_half;
                offs[3] = p_half + p_quarter;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Modulators
    // ----------------------------------------------------------------
    // Shared ramp counter; a zero period parks it at zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= 16'h0000;
        else if (ce)
        begin
            if (cnt_reg + 16'h0001 >= period_reg)
                cnt_reg <= 16'h0000;
            else
                cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    // Each gate compares its shifted ramp with the duty setting
    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_pwm
            logic [16:0] sum;
            logic [15:0] pos;

            assign sum = {1'b0, cnt_reg} + {1'b0, offs[g]};
            assign pos = (sum >= {1'b0, period_reg})
                       ? 16'(sum - {1'b0, period_reg}) : sum[15:0];

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    gate_reg[g] <= 1'b0;
                else if (ce)
                    gate_reg[g] <= active[g] && run_reg && !dif.off
                                   && (pos < duty_reg);
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign gate_out_one   = gate_reg[0];
    assign gate_out_two   = gate_reg[1];
    assign gate_out_three = gate_reg[2];
    assign gate_out_four  = gate_reg[3];
    assign save_mode      = save_reg;
    assign output_off     = dif.off;
    assign dac_target_uv  = dif.dac_uv;
    assign current_limit  = ilim_eff_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_request_forces: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !req_n_sync && !en_sync) |=> save_reg)
        else $error("Save request did not force saving mode");
    a_auto_enter: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && en_sync && dif.down) |=> auto_reg)
        else $error("Voltage drop did not set auto saving");
    a_auto_exit: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && en_sync && dif.up && !dif.down) |=> !auto_reg)
        else $error("Voltage rise did not clear auto saving");
    a_auto_gated: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !en_sync) |=> !auto_reg)
        else $error("Auto saving active while disabled");
    a_single_phase: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && save_reg) |=> !(gate_out_two || gate_out_three
                               || gate_out_four))
        else $error("Shed phase still switching");
    a_two_phase: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && phase_reg == PH_TWO) |=> !(gate_out_two || gate_out_four))
        else $error("Unused gate driven in two-phase mode");
    a_three_phase: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && phase_reg == PH_THREE) |=> !gate_out_four)
        else $error("Gate four driven in three-phase mode");
    a_limit_scale: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && save_reg && phase_reg == PH_FOUR)
        |=> (ilim_eff_reg == ($past(ilim_reg) >> 2)))
        else $error("Current limit not scaled to one phase");
    a_four_phase: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !save_reg && phase_reg == PH_FOUR && run_reg && !dif.off
         && duty_reg > period_reg) |=> (gate_reg == 4'hf))
        else $error("Four-phase mode not driving every gate");

endmodule

`default_nettype wire

// ---- vps_pkg.sv ----
// Package: register map, reset values and code-table constants
package vps_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets on APB
    // ----------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_PERIOD   = 8'h04;
    localparam logic [7:0]  REG_DUTY     = 8'h08;
    localparam logic [7:0]  REG_ILIM     = 8'h0c;
    localparam logic [7:0]  REG_STATUS   = 8'h10;
    localparam logic [7:0]  REG_DAC      = 8'h14;
    localparam logic [7:0]  REG_ILIM_EFF = 8'h18;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_PHASE_LSB = 0;   // Phase count, 3 bits
    localparam int CTRL_RUN_BIT   = 8;   // Modulation enable
    localparam int ST_SAVE_BIT    = 0;
    localparam int ST_OFF_BIT     = 1;
    localparam int ST_AUTO_BIT    = 2;
    localparam int ST_REQ_BIT     = 3;
    localparam int ST_CODE_LSB    = 4;   // Held code, 8 bits
    localparam int ST_GATES_LSB   = 12;  // Gate mask, 4 bits

    // ----------------------------------------------------------------
    // Phase counts and reset values
    // ----------------------------------------------------------------
    localparam logic [2:0]  PH_TWO       = 3'h2;
    localparam logic [2:0]  PH_THREE     = 3'h3;
    localparam logic [2:0]  PH_FOUR      = 3'h4;
    localparam logic [2:0]  PHASE_RST    = PH_FOUR;
    localparam logic        RUN_RST      = 1'b0;
    localparam logic [15:0] PERIOD_RST   = 16'h00fa;
    localparam logic [15:0] DUTY_RST     = 16'h0000;
    localparam logic [15:0] ILIM_RST     = 16'hffff;

    // ----------------------------------------------------------------
    // Code table: target in microvolts
    // ----------------------------------------------------------------
    localparam logic [7:0]  CODE_FIRST   = 8'h02;   // Highest target
    localparam logic [7:0]  CODE_LAST    = 8'hb2;   // Lowest target
    localparam logic [7:0]  CODE_OFF_A   = 8'hfe;
    localparam logic [7:0]  CODE_OFF_B   = 8'hff;
    localparam logic [20:0] DAC_MAX_UV   = 21'h186a00;  // 1.60000 V
    localparam logic [20:0] DAC_MIN_UV   = 21'h07a120;  // 0.50000 V
    localparam logic [20:0] STEP_UV      = 21'h00186a;  // 6.25 mV

endpackage
